// ---- verilog/nvsc_pkg.sv ----
// Package for the parallel nonvolatile memory host controller.
// Assumes a 10 MHz system clock; all pin timings are counted in cycles of it.
package nvsc_pkg;
   // ----------------------------------------
   // Clock and pin timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CE_ACCESS_NS = 60;         // Chip enable access time
   localparam int PAGE_ACCESS_NS = 28;       // page_access_time
   localparam int PRECHARGE_MIN_NS = 55;     // precharge_min_time
   localparam int RANDOM_CYCLE_NS = 115;     // random_cycle_time
   localparam int PAGE_STABLE_NS = 15;       // Low address hold in page mode
   localparam int DATA_SETUP_NS = 20;        // Write data setup before ending edge
   // Least times round up, at least one cycle
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ACCESS_CYC = ns_to_cyc(CE_ACCESS_NS);
   localparam int PAGE_CYC = ns_to_cyc(PAGE_ACCESS_NS);
   localparam int PRECHARGE_CYC = ns_to_cyc(PRECHARGE_MIN_NS);
   localparam int CYCLE_CYC = ns_to_cyc(RANDOM_CYCLE_NS);
   localparam int SETUP_CYC = ns_to_cyc(DATA_SETUP_NS);
   localparam int PAGE_HOLD_CYC = ns_to_cyc(PAGE_STABLE_NS);
   localparam int CNT_W = 4;

   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam int COL_W = 2;                 // Column bits within a row
   localparam int BYTE_W = 8;

   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [2:0] {
      NVSC_IDLE = 3'h0,
      NVSC_ACCESS = 3'h1,
      NVSC_WSTROBE = 3'h3,
      NVSC_OPEN = 3'h2,
      NVSC_PRECHG = 3'h6
   } nvsc_state_t;
endpackage

// ---- verilog/nvsc_tmr_if.sv ----
// Interface between the host sequencer and its wait counter.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
interface nvsc_tmr_if;
   import nvsc_pkg::*;
   logic load;
   logic [CNT_W-1:0] count;
   logic done;
   modport ctrl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// ---- verilog/nvsc_timer.sv ----
// Down counter that times pin intervals for the host sequencer.
// Assumes loads come from logic on the same clock.
`timescale 1ns/1ps
module nvsc_timer
   import nvsc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sequencer side
   nvsc_tmr_if.tmr t
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // --------------------------------------
   // Count down to zero after each load
   // --------------------------------------
   assign cnt_d = t.load ? t.count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
   // Done comes from the register only, so no loop back through load
   assign t.done = (cnt_q == '0);

   // Counter register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule

// ---- verilog/nvsc_host.sv ----
// Host controller that drives a parallel nonvolatile memory by its pins.
// Assumes the memory pins sit outside this clock; read data is synchronised.
`timescale 1ns/1ps
module nvsc_host
   import nvsc_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // User request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [AW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   input wire logic [1:0] req_byte_en,
   output logic req_ready,
   // User answer
   output logic rsp_valid,
   output logic [DW-1:0] rsp_rdata,
   // Memory pins
   output logic chip_select_low_n,
   output logic chip_select_high,
   output logic write_strobe_n,
   output logic output_gate_n,
   output logic upper_byte_select_n,
   output logic lower_byte_select_n,
   output logic [AW-1:0] mem_addr,
   input wire logic [DW-1:0] mem_dq_i,
   output logic [DW-1:0] mem_dq_o,
   output logic mem_dq_oe
);
   nvsc_state_t st_q, st_d;
   logic open_q;
   logic wr_q;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] dq_s1_q, dq_s2_q;
   nvsc_tmr_if tif ();

   // ----------------------------------------
   // Wait counter
   // ----------------------------------------
   nvsc_timer u_tmr (
      .clk (clk),
      .rstn (rstn),
      .t (tif.tmr)
   );

   // ----------------------------------------
   // Decode of next request
   // ----------------------------------------
   wire [AW-1:0] row_mask = {{(AW-COL_W){1'b1}}, {COL_W{1'b0}}};
   wire same_row = open_q && ((req_addr & row_mask) == (addr_q & row_mask));
   // Open row takes at once; idle waits for the precharge count
   wire take = req_valid && (st_q == NVSC_OPEN || (st_q == NVSC_IDLE && tif.done));
   wire page_hit = take && same_row && (st_q == NVSC_OPEN);
   wire [1:0] bsel_n = ~req_byte_en;

   // Next state
   always_comb
   begin
      st_d = st_q;
      tif.load = 1'b0;
      tif.count = '0;
      unique case (st_q)
         NVSC_IDLE, NVSC_OPEN:
         begin
            if (take)
            begin
               st_d = req_write ? NVSC_WSTROBE : NVSC_ACCESS;
               // Random cycle plus data setup for a row, page access plus hold for a column hit
               tif.load = 1'b1;
               tif.count = page_hit ? CNT_W'(PAGE_CYC + PAGE_HOLD_CYC)
                                    : CNT_W'(CYCLE_CYC + SETUP_CYC);
            end
            else if (st_q == NVSC_OPEN && tif.done)
            begin
               st_d = NVSC_PRECHG;
               tif.load = 1'b1;
               tif.count = CNT_W'(PRECHARGE_CYC);
            end
         end
         NVSC_ACCESS, NVSC_WSTROBE:
            if (tif.done)
            begin
               // Row stays open a short window for a page hit
               st_d = NVSC_OPEN;
               tif.load = 1'b1;
               tif.count = CNT_W'(CYCLE_CYC);
            end
         NVSC_PRECHG:
            if (tif.done)
               st_d = NVSC_IDLE;
         default:
            st_d = NVSC_IDLE;
      endcase
   end

   // ----------------------------------------
   // Pin and state registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_q <= NVSC_IDLE;
         open_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= '0;
         chip_select_low_n <= 1'b1;
         chip_select_high <= 1'b1;
         write_strobe_n <= 1'b1;
         output_gate_n <= 1'b1;
         upper_byte_select_n <= 1'b1;
         lower_byte_select_n <= 1'b1;
         mem_addr <= '0;
         mem_dq_o <= '0;
         mem_dq_oe <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         st_q <= st_d;
         req_ready <= take;
         rsp_valid <= 1'b0;
         if (take)
         begin
            // Address and strobe set one cycle before the enable edge
            addr_q <= req_addr;
            mem_addr <= req_addr;
            wr_q <= req_write;
            upper_byte_select_n <= bsel_n[1];
            lower_byte_select_n <= bsel_n[0];
            mem_dq_o <= req_wdata;
            mem_dq_oe <= req_write;
            write_strobe_n <= ~req_write;
            output_gate_n <= req_write;
            open_q <= 1'b1;
         end
         else if (req_ready)
         begin
            // Enable falls once address and strobe have settled
            chip_select_low_n <= 1'b0;
         end
         else if ((st_q == NVSC_ACCESS || st_q == NVSC_WSTROBE) && tif.done)
         begin
            // Write ends on strobe rise; data held until then
            write_strobe_n <= 1'b1;
            output_gate_n <= 1'b1;
            if (!wr_q)
            begin
               rsp_rdata <= dq_s2_q;
            end
            rsp_valid <= 1'b1;
         end
         else if (st_d == NVSC_PRECHG)
         begin
            chip_select_low_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            open_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read data synchroniser
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
      end
      else
      begin
         dq_s1_q <= mem_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end
endmodule

// ---- tb/nvsc_host_properties.sv ----
// Pin-level assertions for the memory host controller.
// Assumes one clock domain; bound into nvsc_host at the foot.
`timescale 1ns/1ps
module nvsc_host_properties
   import nvsc_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
)
(
   // Clock, reset and handshake
   input wire logic clk,
   input wire logic rstn,
   input wire logic req_ready,
   input wire logic rsp_valid,
   // Memory pins
   input wire logic chip_select_low_n,
   input wire logic chip_select_high,
   input wire logic write_strobe_n,
   input wire logic output_gate_n,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [DW-1:0] mem_dq_o,
   input wire logic mem_dq_oe
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Strobe low through access and data setup
   sequence s_strobe_hold;
      !write_strobe_n [*3];
   endsequence
   a_strobe_held: assert property ($fell(write_strobe_n) |-> s_strobe_hold)
      else $error("strobe pulse short");
   a_strobe_end: assert property ($rose(write_strobe_n) |-> rsp_valid)
      else $error("strobe end without answer");
   a_data_steady: assert property (!write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_dq_o))
      else $error("write data moved");
   a_no_contention: assert property (!output_gate_n && write_strobe_n |-> !mem_dq_oe)
      else $error("host drives during read");
   a_high_enable: assert property (chip_select_high)
      else $error("high enable dropped");
   a_strobe_enabled: assert property (!write_strobe_n |-> !chip_select_low_n || req_ready)
      else $error("strobe low while deselected");
   a_column_hold: assert property ($changed(mem_addr[2:0]) && !chip_select_low_n |=> $stable(mem_addr[2:0]))
      else $error("column moved early");
   a_cycle_gap: assert property (req_ready |=> !req_ready [*2])
      else $error("requests too close");
   a_read_answer: assert property (req_ready && write_strobe_n |-> ##[1:4] rsp_valid)
      else $error("read answer late");
   a_select_active: assert property (req_ready |=> !chip_select_low_n)
      else $error("access without select");
endmodule
bind nvsc_host nvsc_host_properties #(.AW(AW), .DW(DW)) u_props (.clk(clk), .rstn(rstn),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .chip_select_low_n(chip_select_low_n),
   .chip_select_high(chip_select_high), .write_strobe_n(write_strobe_n),
   .output_gate_n(output_gate_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o),
   .mem_dq_oe(mem_dq_oe));

// ---- tb/nvsc_mem_model.sv ----
// Behavioural model of the parallel nonvolatile memory device.
// Assumes host pin levels only; the device has no clock.
`timescale 1ns/1ps
module nvsc_mem_model
   import nvsc_pkg::*;
(
   // Control pins
   input wire logic cs_n,
   input wire logic cs_hi,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic ub_n,
   input wire logic lb_n,
   // Address and data
   input wire logic [ADDR_W-1:0] a,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic [1:0] dq_en
);
   logic [DATA_W-1:0] mem [int];
   logic vld = 1'b0;
   int lat = CE_ACCESS_NS; // Bench may shorten it
   // New access on enable edge or address change
   always @(negedge cs_n or posedge cs_hi or a)
   begin
      vld = 1'b0;
      #(lat);
      vld = !cs_n && cs_hi;
      dq_out = mem.exists(a) ? mem[a] : '0;
   end
   // Write lands at first ending edge
   always @(posedge we_n or posedge cs_n)
      if (cs_n != we_n && cs_hi)
      begin
         if (!mem.exists(a)) mem[a] = '0;
         if (!ub_n) mem[a][15:8] = dq_in[15:8];
         if (!lb_n) mem[a][7:0] = dq_in[7:0];
         dq_out = mem[a];
      end
   // Lanes driven only when read enabled
   assign dq_en[1] = vld && we_n && !oe_n && !ub_n;
   assign dq_en[0] = vld && we_n && !oe_n && !lb_n;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the host controller against a device model.
// Assumes the model and checker files are compiled first.
`timescale 1ns/1ps
module testbench;
   import nvsc_pkg::*;
   // ----------------------------------------
   // Signals and wiring
   // ----------------------------------------
   logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, pat = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0, mem_addr;
   logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_dq_i, mem_dq_o, dev_dq;
   logic [1:0] req_byte_en = 2'h3, dev_en;
   logic req_ready, rsp_valid, chip_select_low_n, chip_select_high, write_strobe_n;
   logic output_gate_n, upper_byte_select_n, lower_byte_select_n, mem_dq_oe;
   logic [DATA_W-1:0] ref_mem [int];
   int miscompares = 0, samples_checked = 0;
   always #50 clk = ~clk;
   always @(posedge clk) pat <= ~pat;
   // Bus level: host, device lanes, else a toggling pattern
   assign mem_dq_i[15:8] = mem_dq_oe ? mem_dq_o[15:8] : dev_en[1] ? dev_dq[15:8] : {8{pat}};
   assign mem_dq_i[7:0] = mem_dq_oe ? mem_dq_o[7:0] : dev_en[0] ? dev_dq[7:0] : {8{pat}};
   nvsc_host i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
      .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
      .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
      .mem_addr(mem_addr), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
   nvsc_mem_model i_dev (.cs_n(chip_select_low_n), .cs_hi(chip_select_high),
      .we_n(write_strobe_n), .oe_n(output_gate_n), .ub_n(upper_byte_select_n),
      .lb_n(lower_byte_select_n), .a(mem_addr), .dq_in(mem_dq_i), .dq_out(dev_dq), .dq_en(dev_en));
   // Word after a masked write
   function automatic logic [15:0] merged(logic [15:0] old, logic [15:0] d, logic [1:0] be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction
   function automatic logic [15:0] expect_at(int a);
      return ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic compare(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One request held until taken, then its answer
   task automatic op(logic w, logic [18:0] a, logic [15:0] d, logic [1:0] be);
      int n;
      logic [15:0] m;
      m = merged(16'h0000, 16'hffff, be);
      n = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_byte_en <= be;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 20);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      if (rsp_valid !== 1'b1)
      begin
         miscompares++;
         complete_run();
      end
      if (w)
         ref_mem[a] = merged(expect_at(a), d, be);
      else
         compare("read data", expect_at(a) & m, rsp_rdata & m);
   endtask
   // Corner lanes, random page traffic, reset retention
   initial
   begin
      void'($urandom(68));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int b = 1; b < 4; b++)
      begin
         op(1'b1, 19'h7ffff, 16'($urandom), 2'(b));
         op(1'b0, 19'h7ffff, 16'h0000, 2'(b));
         op(1'b0, 19'h00000, 16'h0000, 2'(b));
      end
      for (int k = 0; k < 60; k++)
      begin
         i_dev.lat = (k < 30) ? CE_ACCESS_NS : 10;
         op(1'($urandom), {17'($urandom_range(0, 2) * 50000), 2'($urandom)}, 16'($urandom),
            2'($urandom_range(1, 3)));
      end
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      op(1'b0, 19'h7ffff, 16'h0000, 2'h3);
      complete_run();
   end
endmodule
